// ===== src/ilc_top.sv
// four level prioritised interrupt controller with an AXI4-Lite slave
`timescale 1ns/100ps
`include "ilc_cfg.svh"
module ilc_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire ilc_pkg::ilc_src_t src_set,
  input wire logic external_request_0_n,
  input wire logic external_request_1_n,
  output logic cpu_irq_req,
  output logic [15:0] cpu_vector,
  output ilc_pkg::ilc_lvl_t cpu_level,
  input wire logic cpu_call_ack,
  input wire logic cpu_return_from_interrupt_done,
  input wire logic cpu_instr_done,
  output logic irq
);
  import ilc_pkg::*;
  //////////////////////////////////////////////////////////////////////////
  // state
  logic glb_reg, hold_reg, hold_next, req_reg, req_next;
  logic aw_got_reg, w_got_reg, bv_reg, rv_reg;
  ilc_src_t en_reg, plo_reg, phi_reg, pend_reg, pend_next;
  logic [1:0] evt_reg, evt_next, emask_reg, br_reg, rr_reg;
  logic [1:0] sy1_reg, sy2_reg, sy3_reg, flt_reg, flt_next;
  ilc_idx_t idx_reg;
  ilc_lvl_t lvl_reg;
  logic [7:0] awa_reg;
  logic [31:0] wd_reg, rd_reg;
  logic [3:0] ws_reg;
  logic svc_cur_valid;
  ilc_lvl_t svc_cur_lvl;
  //////////////////////////////////////////////////////////////////////////
  // external request pins: three flops, change taken when 2nd and 3rd agree
  logic [1:0] ext_fall;
  assign flt_next = (sy2_reg == sy3_reg) ? sy3_reg : flt_reg;
  assign ext_fall = flt_reg & ~flt_next;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sy1_reg <= 2'h3;
      sy2_reg <= 2'h3;
      sy3_reg <= 2'h3;
      flt_reg <= 2'h3;
    end
    else if (ce)
    begin
      sy1_reg <= {external_request_1_n, external_request_0_n};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      flt_reg <= flt_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite decode
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wr_old;
  logic [31:0] wr_val;
  logic wr_ctrl;
  logic wr_en;
  logic wr_plo;
  logic wr_phi;
  logic wr_pend;
  logic wr_emask;
  logic wr_hit;
  logic rd_hit;
  logic rd_evt;
  logic [31:0] rd_val;
  assign s_axi_awready = !aw_got_reg && !bv_reg;
  assign s_axi_wready = !w_got_reg && !bv_reg;
  assign s_axi_arready = !rv_reg;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_go = aw_got_reg && w_got_reg && !bv_reg;
  assign wmask = {{8{ws_reg[3]}}, {8{ws_reg[2]}},
                  {8{ws_reg[1]}}, {8{ws_reg[0]}}};
  assign wr_ctrl = wr_go && awa_reg == `ILC_OFS_CTRL;
  assign wr_en = wr_go && awa_reg == `ILC_OFS_ENABLE;
  assign wr_plo = wr_go && awa_reg == `ILC_OFS_PRIO_LO;
  assign wr_phi = wr_go && awa_reg == `ILC_OFS_PRIO_HI;
  assign wr_pend = wr_go && awa_reg == `ILC_OFS_PENDING;
  assign wr_emask = wr_go && awa_reg == `ILC_OFS_EVT_MASK;
  assign wr_hit = wr_ctrl || wr_en || wr_plo || wr_phi || wr_pend ||
                  wr_emask || awa_reg == `ILC_OFS_SERVICE ||
                  awa_reg == `ILC_OFS_EVT_STAT;
  assign wr_old = wr_ctrl ? {31'h0, glb_reg} :
                  wr_en ? {13'h0, en_reg} :
                  wr_plo ? {13'h0, plo_reg} :
                  wr_phi ? {13'h0, phi_reg} :
                  wr_pend ? {13'h0, pend_reg} :
                  {30'h0, emask_reg};
  assign wr_val = (wr_old & ~wmask) | (wd_reg & wmask);
  assign rd_evt = ar_hs && s_axi_araddr == `ILC_OFS_EVT_STAT;
  assign rd_val =
    s_axi_araddr == `ILC_OFS_CTRL ? {31'h0, glb_reg} :
    s_axi_araddr == `ILC_OFS_ENABLE ? {13'h0, en_reg} :
    s_axi_araddr == `ILC_OFS_PRIO_LO ? {13'h0, plo_reg} :
    s_axi_araddr == `ILC_OFS_PRIO_HI ? {13'h0, phi_reg} :
    s_axi_araddr == `ILC_OFS_PENDING ? {13'h0, pend_reg} :
    s_axi_araddr == `ILC_OFS_SERVICE ?
      {23'h0, req_reg, idx_reg, svc_cur_valid,
       svc_cur_lvl} :
    s_axi_araddr == `ILC_OFS_EVT_STAT ? {30'h0, evt_reg} :
    {30'h0, emask_reg};
  assign rd_hit = s_axi_araddr <= `ILC_OFS_EVT_MASK &&
                  s_axi_araddr[1:0] == 2'h0;
  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0;
      ws_reg <= 4'h0;
      bv_reg <= 1'b0;
      br_reg <= `ILC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_hs)
      begin
        aw_got_reg <= 1'b1;
        awa_reg <= s_axi_awaddr;
      end
      if (w_hs)
      begin
        w_got_reg <= 1'b1;
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bv_reg <= 1'b1;
        br_reg <= wr_hit ? `ILC_RESP_OKAY : `ILC_RESP_SLVERR;
      end
      else if (bv_reg && s_axi_bready)
        bv_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= `ILC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (ar_hs)
      begin
        rv_reg <= 1'b1;
        rd_reg <= rd_hit ? rd_val : 32'h0;
        rr_reg <= rd_hit ? `ILC_RESP_OKAY : `ILC_RESP_SLVERR;
      end
      else if (rv_reg && s_axi_rready)
        rv_reg <= 1'b0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // arbitration and in-service record
  ilc_arb_if arb_bus ();
  ilc_svc_t svc_bits;
  logic take;
  logic preempt_ok;
  logic cand;
  ilc_src_t hw_set;
  ilc_src_t auto_clr;
  // the reserved slot never requests; global enable gates all sources
  assign arb_bus.req = pend_reg & en_reg & ~`ILC_RSV_MASK &
                       {ILC_NSRC{glb_reg}};
  assign arb_bus.prio_lo = plo_reg;
  assign arb_bus.prio_hi = phi_reg;
  ilc_prio_arb u_arb
  (
    .bus(arb_bus.arb)
  );
  ilc_level_stack u_stack
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .push(take),
    .push_lvl(lvl_reg),
    .pop(cpu_return_from_interrupt_done),
    .in_svc(svc_bits),
    .cur_valid(svc_cur_valid),
    .cur_lvl(svc_cur_lvl)
  );
  assign take = cpu_call_ack && req_reg;
  // strictly higher only, so level 3 is never preempted
  assign preempt_ok = !svc_cur_valid ||
                      arb_bus.win_lvl > svc_cur_lvl;
  assign cand = arb_bus.win_valid && preempt_ok;
  // after a return, wait for one completed instruction
  assign hold_next = cpu_return_from_interrupt_done ? 1'b1 :
                     cpu_instr_done ? 1'b0 : hold_reg;
  // one detect cycle; dropped while the core takes the call
  assign req_next = cand && !hold_next && !take;
  //////////////////////////////////////////////////////////////////////////
  // pending flags: hardware set wins over any clear
  always_comb
  begin
    hw_set = src_set;
    hw_set[`ILC_BIT_EXT0] = src_set[`ILC_BIT_EXT0] | ext_fall[0];
    hw_set[`ILC_BIT_EXT1] = src_set[`ILC_BIT_EXT1] | ext_fall[1];
  end
  assign auto_clr = take ? (`ILC_AUTO_CLR &
                            19'(19'h1 << idx_reg)) : 19'h0;
  assign pend_next = (((wr_pend ? wr_val[18:0] : pend_reg) & ~auto_clr) |
                      hw_set) & ~`ILC_RSV_MASK;
  assign evt_next = ((rd_evt ? 2'h0 : evt_reg) |
                     {cpu_return_from_interrupt_done, take});
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      glb_reg <= 1'b0;
      en_reg <= `ILC_RST_SRC;
      plo_reg <= `ILC_RST_SRC;
      phi_reg <= `ILC_RST_SRC;
      pend_reg <= `ILC_RST_SRC;
      evt_reg <= 2'h0;
      emask_reg <= 2'h0;
    end
    else if (ce)
    begin
      if (wr_ctrl)
        glb_reg <= wr_val[`ILC_BIT_GLOBAL];
      if (wr_en)
        en_reg <= wr_val[18:0];
      if (wr_plo)
        plo_reg <= wr_val[18:0];
      if (wr_phi)
        phi_reg <= wr_val[18:0];
      if (wr_emask)
        emask_reg <= wr_val[1:0];
      pend_reg <= pend_next;
      evt_reg <= evt_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // request towards the core, re-judged every clock
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hold_reg <= 1'b0;
      req_reg <= 1'b0;
      idx_reg <= 5'h00;
      lvl_reg <= 2'h0;
    end
    else if (ce)
    begin
      hold_reg <= hold_next;
      req_reg <= req_next;
      idx_reg <= arb_bus.win_idx;
      lvl_reg <= arb_bus.win_lvl;
    end
  end
  assign cpu_irq_req = req_reg;
  assign cpu_vector = `ILC_VEC_BASE +
                      16'({idx_reg, 3'h0});
  assign cpu_level = lvl_reg;
  assign irq = |(evt_reg & emask_reg);
  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_return_from_interrupt;
    ce && cpu_return_from_interrupt_done;
  endsequence
  sequence s_quiet_after;
    !cpu_irq_req;
  endsequence
  AST_GLOBAL_OFF:
    assert property (ce && !glb_reg |=> !cpu_irq_req)
    else $error("request raised while global enable low");
  AST_DETECT:
    assert property (ce && cand && !hold_next && !take |=> cpu_irq_req)
    else $error("request not raised one cycle after detection");
  AST_RETURN_FROM_INTERRUPT_HOLD:
    assert property (s_return_from_interrupt |=> s_quiet_after)
    else $error("request raised before instruction after return");
  AST_LEVEL3:
    assert property (svc_bits[3] |-> !cpu_irq_req)
    else $error("level 3 routine preempted");
  AST_PREEMPT:
    assert property (cpu_irq_req && svc_cur_valid |->
                     cpu_level > svc_cur_lvl)
    else $error("request not above level in service");
  AST_VECTOR:
    assert property (cpu_irq_req |-> cpu_vector >= 16'h0003 &&
                     cpu_vector <= 16'h0093 && cpu_vector != 16'h006B)
    else $error("vector out of range");
  AST_AUTO_CLR:
    assert property (ce && take && idx_reg == 5'h00 && !hw_set[0] &&
                     !wr_pend |=> !pend_reg[0])
    else $error("ext0 flag not cleared on vectoring");
  AST_KEEP_FLAG:
    assert property (ce && take && idx_reg == 5'h04 && !wr_pend |=>
                     pend_reg[4])
    else $error("software cleared flag dropped by hardware");
  AST_WINNER:
    assert property (ce && req_next |=>
                     cpu_level == $past(arb_bus.win_lvl))
    else $error("served level differs from highest request");
  AST_RESET_PRIO:
    assert property (!$past(aresetn) |-> plo_reg == 19'h0 &&
                     phi_reg == 19'h0)
    else $error("priority bits not zero after reset");
endmodule

// ===== src/ilc_cfg.svh
// register map, reset values and fixed figures of the interrupt controller
`ifndef ILC_CFG_SVH
`define ILC_CFG_SVH
`define ILC_OFS_CTRL 8'h00
`define ILC_OFS_ENABLE 8'h04
`define ILC_OFS_PRIO_LO 8'h08
`define ILC_OFS_PRIO_HI 8'h0C
`define ILC_OFS_PENDING 8'h10
`define ILC_OFS_SERVICE 8'h14
`define ILC_OFS_EVT_STAT 8'h18
`define ILC_OFS_EVT_MASK 8'h1C
`define ILC_RST_SRC 19'h00000
`define ILC_RSV_MASK 19'h02000
`define ILC_AUTO_CLR 19'h0000F
`define ILC_BIT_GLOBAL 0
`define ILC_BIT_EXT0 0
`define ILC_BIT_EXT1 2
`define ILC_EVT_CALL 0
`define ILC_EVT_RETURN_FROM_INTERRUPT 1
`define ILC_VEC_BASE 16'h0003
`define ILC_VEC_SHIFT 3
`define ILC_DETECT_CYC 1
`define ILC_RESP_OKAY 2'h0
`define ILC_RESP_SLVERR 2'h2
`endif

// ===== src/ilc_pkg.sv
// types shared by the interrupt controller modules
package ilc_pkg;
  localparam int ILC_NSRC = 19;
  typedef logic [ILC_NSRC-1:0] ilc_src_t;
  typedef logic [4:0] ilc_idx_t;
  typedef logic [1:0] ilc_lvl_t;
  typedef logic [3:0] ilc_svc_t;
endpackage

// ===== src/ilc_arb_if.sv
// carrier between the controller core and its priority arbiter
`timescale 1ns/100ps
interface ilc_arb_if;
  import ilc_pkg::*;
  ilc_src_t req;
  ilc_src_t prio_lo;
  ilc_src_t prio_hi;
  logic win_valid;
  ilc_idx_t win_idx;
  ilc_lvl_t win_lvl;
  modport arb
  (
    input req, prio_lo, prio_hi,
    output win_valid, win_idx, win_lvl
  );
  modport user
  (
    output req, prio_lo, prio_hi,
    input win_valid, win_idx, win_lvl
  );
endinterface

// ===== src/ilc_prio_arb.sv
// picks the highest level request, lowest order number on a tie
`timescale 1ns/100ps
module ilc_prio_arb
(
  ilc_arb_if.arb bus
);
  import ilc_pkg::*;
  always_comb
  begin
    bus.win_valid = 1'b0;
    bus.win_idx = 5'h00;
    bus.win_lvl = 2'h0;
    // walk downward so an equal level at a lower order replaces the pick
    for (int i = ILC_NSRC - 1; i >= 0; i--)
    begin
      if (bus.req[i] &&
          (!bus.win_valid ||
           {bus.prio_hi[i], bus.prio_lo[i]} >= bus.win_lvl))
      begin
        bus.win_valid = 1'b1;
        bus.win_idx = 5'(i);
        bus.win_lvl = {bus.prio_hi[i], bus.prio_lo[i]};
      end
    end
  end
endmodule

// ===== src/ilc_level_stack.sv
// record of the priority levels now in service, one bit per level
`timescale 1ns/100ps
module ilc_level_stack
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic push,
  input wire ilc_pkg::ilc_lvl_t push_lvl,
  input wire logic pop,
  output ilc_pkg::ilc_svc_t in_svc,
  output logic cur_valid,
  output ilc_pkg::ilc_lvl_t cur_lvl
);
  import ilc_pkg::*;
  ilc_svc_t svc_reg;
  ilc_svc_t svc_next;
  ilc_svc_t top_bit;
  assign cur_valid = |svc_reg;
  assign cur_lvl = svc_reg[3] ? 2'h3 : svc_reg[2] ? 2'h2 :
                   svc_reg[1] ? 2'h1 : 2'h0;
  assign top_bit = cur_valid ? 4'(4'h1 << cur_lvl) : 4'h0;
  assign svc_next = push ? (svc_reg | 4'(4'h1 << push_lvl)) :
                    pop ? (svc_reg & ~top_bit) : svc_reg;
  assign in_svc = svc_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      svc_reg <= 4'h0;
    else if (ce)
      svc_reg <= svc_next;
  end
endmodule

// ===== dv/ilc_cpu_model.sv
// behavioural core that takes vector calls and runs return sequences
`timescale 1ns/100ps
module ilc_cpu_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cpu_irq_req,
  input wire logic [3:0] ack_dly,
  input wire logic [3:0] instr_len,
  input wire logic do_return_from_interrupt,
  output logic cpu_call_ack,
  output logic cpu_return_from_interrupt_done,
  output logic cpu_instr_done
);
  logic [3:0] wait_reg;
  logic [3:0] instr_reg;
  always_ff @(posedge aclk)
  begin
    cpu_call_ack <= 1'b0;
    cpu_return_from_interrupt_done <= 1'b0;
    cpu_instr_done <= 1'b0;
    if (!aresetn)
    begin
      wait_reg <= 4'h0;
      instr_reg <= 4'h0;
    end
    else
    begin
      // the call completes ack_dly cycles after the request is seen
      if (!cpu_irq_req || cpu_call_ack)
        wait_reg <= 4'h0;
      else if (wait_reg >= ack_dly)
        cpu_call_ack <= 1'b1;
      else
        wait_reg <= wait_reg + 4'h1;
      // one instruction of instr_len cycles follows a return
      if (do_return_from_interrupt)
      begin
        cpu_return_from_interrupt_done <= 1'b1;
        instr_reg <= instr_len;
      end
      else if (instr_reg != 4'h0)
      begin
        instr_reg <= instr_reg - 4'h1;
        cpu_instr_done <= (instr_reg == 4'h1);
      end
    end
  end
endmodule

// ===== dv/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/100ps
`include "ilc_cfg.svh"
module testbench;
  import ilc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd_val, r, seed = 32'd88982;
  ilc_src_t src_set = '0;
  ilc_src_t lo, hi, pend;
  logic external_request_0_n = 1'b1;
  logic external_request_1_n = 1'b1;
  logic cpu_irq_req, cpu_call_ack, cpu_return_from_interrupt_done, cpu_instr_done, irq;
  logic [15:0] cpu_vector;
  ilc_lvl_t cpu_level;
  logic [3:0] ack_dly = 4'h0;
  logic [3:0] instr_len = 4'h1;
  logic do_return_from_interrupt = 1'b0;
  logic [6:0] w;
  int n_mismatch = 0;
  int tests_run = 0;
  always #2 aclk = ~aclk;
  ilc_top DUT (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .src_set, .external_request_0_n, .external_request_1_n, .cpu_irq_req,
    .cpu_vector, .cpu_level, .cpu_call_ack, .cpu_return_from_interrupt_done, .cpu_instr_done,
    .irq);
  ilc_cpu_model CPU (.aclk, .aresetn, .cpu_irq_req, .ack_dly, .instr_len,
    .do_return_from_interrupt, .cpu_call_ack, .cpu_return_from_interrupt_done, .cpu_instr_done);
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // expected winner {level, order}: highest level, lowest order on a tie
  function automatic logic [6:0] pick(ilc_src_t p, ilc_src_t l, ilc_src_t h);
    logic [1:0] bl;
    logic [4:0] bi;
    bl = 2'h0;
    bi = 5'h00;
    for (int i = 18; i >= 0; i--)
      if (p[i] && {h[i], l[i]} >= bl)
      begin
        bl = {h[i], l[i]};
        bi = 5'(i);
      end
    return {bl, bi};
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = (s_axi_bvalid === 1'b1);
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = (s_axi_rvalid === 1'b1);
      rd_val = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  task wait_req(input logic v);
    int k;
    k = 0;
    do
    begin
      @(negedge aclk);
      k++;
    end
    while (cpu_irq_req !== v && k < 60);
    chk(cpu_irq_req, v);
  endtask
  // a return, then the request must stay low until one instruction is done
  task ret;
    int k;
    @(posedge aclk);
    do_return_from_interrupt <= 1'b1;
    @(posedge aclk);
    do_return_from_interrupt <= 1'b0;
    k = 0;
    while (cpu_instr_done !== 1'b1 && k < 20)
    begin
      @(negedge aclk);
      chk(cpu_irq_req, 0);
      k++;
    end
    chk(cpu_instr_done, 1);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // whole run is under a thousand cycles; the limit of 50000 cycles leaves a wide margin
  initial
  begin
    #200000;
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`ILC_OFS_PRIO_LO);
    chk(rd_val, 0);
    rd(`ILC_OFS_PRIO_HI);
    chk(rd_val, 0);
    chk(irq, 0);
    rd(8'h20);
    chk(resp, `ILC_RESP_SLVERR);
    wr(`ILC_OFS_CTRL, 32'h1);
    wr(`ILC_OFS_ENABLE, 32'h7FFFF);
    wr(`ILC_OFS_EVT_MASK, 32'h3);
    chk(resp, `ILC_RESP_OKAY);
    wr(8'h20, 32'h1);
    chk(resp, `ILC_RESP_SLVERR);
    for (int it = 0; it < 16; it++)
    begin
      r = rnd();
      lo = (it == 0) ? '0 : r[18:0];
      r = rnd();
      hi = (it == 0) ? '0 : r[18:0];
      ack_dly <= r[31:28];
      r = rnd();
      pend = (it == 0) ? 19'h7DFFF : (it == 1) ? 19'h40000 : r[18:0];
      pend[13] = 1'b0;
      if (pend == '0) pend = 19'h00001;
      wr(`ILC_OFS_PRIO_LO, 32'(lo));
      wr(`ILC_OFS_PRIO_HI, 32'(hi));
      wr(`ILC_OFS_PENDING, 32'(pend));
      w = pick(pend, lo, hi);
      wait_req(1);
      chk(cpu_vector, 16'h0003 + 16'(w[4:0]) * 16'h8);
      chk(cpu_level, w[6:5]);
      wait_req(0);
      repeat (3) @(negedge aclk) chk(cpu_irq_req, 0);
      rd(`ILC_OFS_PENDING);
      chk(rd_val, 32'(pend & ~(`ILC_AUTO_CLR & (19'h1 << w[4:0]))));
      wr(`ILC_OFS_PENDING, 32'h0);
      ret;
    end
    wr(`ILC_OFS_PRIO_LO, 32'h00220);
    wr(`ILC_OFS_PRIO_HI, 32'h002C0);
    ack_dly <= 4'h0;
    @(posedge aclk);
    src_set <= 19'h00020;
    @(posedge aclk);
    src_set <= '0;
    @(negedge aclk) chk(cpu_irq_req, 0);
    @(negedge aclk) chk(cpu_irq_req, 1);
    wait_req(0);
    wr(`ILC_OFS_PENDING, 32'h00040);
    wait_req(1);
    chk(cpu_vector, 16'h0033);
    wait_req(0);
    wr(`ILC_OFS_PENDING, 32'h00080);
    repeat (4) @(negedge aclk) chk(cpu_irq_req, 0);
    wr(`ILC_OFS_PENDING, 32'h00280);
    wait_req(1);
    chk(cpu_vector, 16'h004B);
    wait_req(0);
    wr(`ILC_OFS_PENDING, 32'h00180);
    repeat (4) @(negedge aclk) chk(cpu_irq_req, 0);
    // no request, winner order 7, level 3 in service
    rd(`ILC_OFS_SERVICE);
    chk(rd_val, 32'h3F);
    ret;
    repeat (4) @(negedge aclk) chk(cpu_irq_req, 0);
    instr_len <= 4'h8;
    ret;
    wait_req(1);
    chk(cpu_vector, 16'h003B);
    wait_req(0);
    wr(`ILC_OFS_PENDING, 32'h0);
    ret;
    ret;
    wr(`ILC_OFS_CTRL, 32'h0);
    wr(`ILC_OFS_PENDING, 32'h1);
    repeat (6) @(negedge aclk) chk(cpu_irq_req, 0);
    wr(`ILC_OFS_CTRL, 32'h1);
    wait_req(1);
    chk(cpu_vector, 16'h0003);
    wait_req(0);
    ret;
    chk(irq, 1);
    rd(`ILC_OFS_EVT_STAT);
    chk(rd_val, 32'h3);
    repeat (2) @(negedge aclk);
    chk(irq, 0);
    wr(`ILC_OFS_EVT_MASK, 32'h0);
    wr(`ILC_OFS_PENDING, 32'h2);
    wait_req(1);
    wait_req(0);
    ret;
    chk(irq, 0);
    rd(`ILC_OFS_EVT_STAT);
    chk(rd_val, 32'h3);
    wr(`ILC_OFS_CTRL, 32'h0);
    @(posedge aclk);
    external_request_0_n <= 1'b0;
    external_request_1_n <= 1'b0;
    src_set <= 19'h02000;
    repeat (10) @(posedge aclk);
    src_set <= '0;
    rd(`ILC_OFS_PENDING);
    chk(rd_val, 32'h5);
    // clock enable low: a set pulse must not land
    @(posedge aclk);
    ce <= 1'b0;
    src_set <= 19'h00010;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    src_set <= '0;
    rd(`ILC_OFS_PENDING);
    chk(rd_val, 32'h5);
    report_and_stop;
  end
endmodule
